// [hdl/iebk_pkg.sv]
// Purpose: Constants and types for the interrupt enable and request bank
// Assumes: 4-bit registers reached on an 8-bit register address
// Notes: Source index 11 down to 0 follows the enable bit order
`default_nettype none
package iebk_pkg;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_SRC = 12;
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned FLAG_BIT = 0;

  localparam logic [7:0] ENABLE_ONE_ADDR = 8'h2d;
  localparam logic [7:0] ENABLE_TWO_ADDR = 8'h2e;
  localparam logic [7:0] ENABLE_THREE_ADDR = 8'h2f;
  localparam logic [7:0] SERIAL3_REQ_ADDR = 8'h34;
  localparam logic [7:0] SERIAL2_REQ_ADDR = 8'h35;
  localparam logic [7:0] TIMER3_REQ_ADDR = 8'h36;
  localparam logic [7:0] TIMER2_REQ_ADDR = 8'h37;
  localparam logic [7:0] TIMER1_REQ_ADDR = 8'h38;
  localparam logic [7:0] REQ_LAST_ADDR = 8'h3f;

  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [3:0] UNMAPPED_READ = 4'h0;

  localparam int unsigned SRC_SERIAL3 = 11;
  localparam int unsigned SRC_SERIAL2 = 10;
  localparam int unsigned SRC_TIMER3 = 9;
  localparam int unsigned SRC_TIMER2 = 8;
  localparam int unsigned SRC_TIMER1 = 7;
  localparam int unsigned SRC_TIMER0 = 6;
  localparam int unsigned SRC_PIN4 = 5;
  localparam int unsigned SRC_CHIP_ENABLE = 0;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] writeData;
    logic writeStrobe;
    logic readStrobe;
  } iebk_bus_req_type;
endpackage : iebk_pkg
`default_nettype wire

// [hdl/iebk_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels from pins
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module iebk_sync #(
  parameter int unsigned WIDTH = 6
) (
  // System
  input wire logic clock,
  input wire logic arst_n,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne_reg;
  logic [WIDTH-1:0] stageTwo_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stageOne_reg <= '0;
      stageTwo_reg <= '0;
    end else begin
      stageOne_reg <= asyncIn;
      stageTwo_reg <= stageOne_reg;
    end
  end

  assign syncOut = stageTwo_reg;
endmodule : iebk_sync
`default_nettype wire

// [hdl/iebk_flag.sv]
// Purpose: One sticky interrupt request flag
// Assumes: All inputs on the clock domain
// Notes: Wipe beats set, set beats a software clear
`timescale 1ns/1ns
`default_nettype none
module iebk_flag (
  // System
  input wire logic clock,
  input wire logic arst_n,
  // Control
  input wire logic wipe,
  input wire logic setPulse,
  input wire logic clearPulse,
  // State
  output logic flag
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (wipe) begin
      flag_next = iebk_pkg::FLAG_RESET;
    end else if (setPulse) begin
      flag_next = 1'b1;
    end else if (clearPulse) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= iebk_pkg::FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  a_set_beats_clear: assert property ( // [RULE10]
    @(posedge clock) disable iff (!arst_n)
    setPulse && clearPulse && !wipe |=> flag)
    else $error("Clear in the set cycle lost the event");
endmodule : iebk_flag
`default_nettype wire

// [hdl/iebk_bank.sv]
// Purpose: Interrupt enable and request register bank
// Assumes: Register port and peripheral events on clock; pins asynchronous
// Notes: Pin requests latch on rising edges of the synchronised level
// Functional notes
// RULE1: Serial 3 interrupt passes only while its enable bit is one.
// RULE2: Serial 2 interrupt is gated by its own enable bit.
// RULE3: Timers 3 to 0 each have their own enable bit.
// RULE4: Each of the five external pins has its own enable bit.
// RULE5: Chip-enable pin interrupt has its own enable bit.
// RULE6: Serial 3 request register shows the flag in bit 0, zeros above.
// RULE7: Timer 3 request register shows its flag, other bits zero.
// RULE8: Timer 2 request register shows its flag, other bits zero.
// RULE9: Power-on and watchdog/stack reset clear enables and flags; others retain.
// RULE10: A source interrupts only with both its flag and enable at one.
`timescale 1ns/1ns
`default_nettype none
module iebk_bank (
  // System
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wdtStackReset,
  // Register port
  input wire iebk_pkg::iebk_bus_req_type busReq,
  output logic [3:0] readData,
  // Internal sources, one-cycle pulses
  input wire logic serial3Event,
  input wire logic serial2Event,
  input wire logic [3:0] timerEvent,
  // External pins, asynchronous levels
  input wire logic [4:0] extIrqPin,
  input wire logic chipEnablePin,
  // Requests to the processor
  output logic [11:0] sourceRequest,
  output logic irq
);
  logic [3:0] enableOne_reg;
  logic [3:0] enableOne_next;
  logic [3:0] enableTwo_reg;
  logic [3:0] enableTwo_next;
  logic [3:0] enableThree_reg;
  logic [3:0] enableThree_next;
  logic [3:0] readData_reg;
  logic [3:0] readData_next;
  logic [5:0] pinLast_reg;
  logic [5:0] pinLast_next;
  logic [2:0] pinPrimed_reg;
  logic [2:0] pinPrimed_next;
  logic causeSeen;
  logic [5:0] pinSync;
  logic [5:0] pinRise;
  logic [11:0] setVec;
  logic [11:0] clearVec;
  logic [11:0] flagVec;
  logic [11:0] enableVec;
  logic writeHit;
  logic readHit;
  logic reqRange;
  logic [7:0] reqOffset;
  logic [3:0] reqIndex;

  // Pin levels cross into the clock domain first
  iebk_sync #(
    .WIDTH(iebk_pkg::NUM_PINS)
  ) u_pin_sync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn({extIrqPin, chipEnablePin}),
    .syncOut(pinSync)
  );

  // Edge detect stays shut for three edges after reset, until the
  // synchroniser and the history both hold the real pin level;
  // otherwise a pin already high at release looks like a rise
  always_comb begin
    pinLast_next = pinSync;
    pinPrimed_next = {pinPrimed_reg[1:0], 1'b1};
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pinLast_reg <= '0;
      pinPrimed_reg <= '0;
    end else begin
      pinLast_reg <= pinLast_next;
      pinPrimed_reg <= pinPrimed_next;
    end
  end

  assign pinRise = pinPrimed_reg[2] ? (pinSync & ~pinLast_reg) : '0;

  // Source order matches the enable bit order, serial 3 highest
  assign setVec = {serial3Event, serial2Event, timerEvent, pinRise};
  assign enableVec = {enableOne_reg, enableTwo_reg, enableThree_reg}; // [RULE3] [RULE4] [RULE5]

  // Request window decode
  assign writeHit = busReq.writeStrobe;
  assign readHit = busReq.readStrobe;
  assign reqRange = (busReq.addr >= iebk_pkg::SERIAL3_REQ_ADDR) &&
                    (busReq.addr <= iebk_pkg::REQ_LAST_ADDR);
  assign reqOffset = busReq.addr - iebk_pkg::SERIAL3_REQ_ADDR;
  assign reqIndex = 4'(iebk_pkg::SRC_SERIAL3) - reqOffset[3:0];

  // Writing a one to the flag bit clears that request
  always_comb begin
    clearVec = '0;
    if (writeHit && reqRange && busReq.writeData[iebk_pkg::FLAG_BIT]) begin
      clearVec[reqIndex] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < iebk_pkg::NUM_SRC; gi++) begin : g_flag
      iebk_flag u_flag (
        .clock(clock),
        .arst_n(arst_n),
        .wipe(wdtStackReset), // [RULE9]
        .setPulse(setVec[gi]),
        .clearPulse(clearVec[gi]),
        .flag(flagVec[gi])
      );
    end
  endgenerate

  // Enable registers
  always_comb begin
    enableOne_next = enableOne_reg;
    enableTwo_next = enableTwo_reg;
    enableThree_next = enableThree_reg;
    if (wdtStackReset) begin
      enableOne_next = iebk_pkg::ENABLE_RESET; // [RULE9]
      enableTwo_next = iebk_pkg::ENABLE_RESET;
      enableThree_next = iebk_pkg::ENABLE_RESET;
    end else if (writeHit) begin
      case (busReq.addr)
        iebk_pkg::ENABLE_ONE_ADDR: begin
          enableOne_next = busReq.writeData; // [RULE1] [RULE2] [RULE3]
        end
        iebk_pkg::ENABLE_TWO_ADDR: begin
          enableTwo_next = busReq.writeData; // [RULE3] [RULE4]
        end
        iebk_pkg::ENABLE_THREE_ADDR: begin
          enableThree_next = busReq.writeData; // [RULE4] [RULE5]
        end
        default: begin
          enableOne_next = enableOne_reg;
        end
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only
  always_comb begin
    readData_next = iebk_pkg::UNMAPPED_READ;
    if (readHit) begin
      case (busReq.addr)
        iebk_pkg::ENABLE_ONE_ADDR: begin
          readData_next = enableOne_reg;
        end
        iebk_pkg::ENABLE_TWO_ADDR: begin
          readData_next = enableTwo_reg;
        end
        iebk_pkg::ENABLE_THREE_ADDR: begin
          readData_next = enableThree_reg;
        end
        default: begin
          if (reqRange) begin
            readData_next = {3'h0, flagVec[reqIndex]}; // [RULE6] [RULE7] [RULE8]
          end
        end
      endcase
    end
  end

  // Chip-enable reset and clock stop have no port: contents simply hold
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enableOne_reg <= iebk_pkg::ENABLE_RESET; // [RULE9]
      enableTwo_reg <= iebk_pkg::ENABLE_RESET;
      enableThree_reg <= iebk_pkg::ENABLE_RESET;
      readData_reg <= iebk_pkg::UNMAPPED_READ;
    end else begin
      enableOne_reg <= enableOne_next;
      enableTwo_reg <= enableTwo_next;
      enableThree_reg <= enableThree_next;
      readData_reg <= readData_next;
    end
  end

  assign readData = readData_reg;
  assign sourceRequest = flagVec & enableVec; // [RULE1] [RULE2] [RULE10]
  assign irq = |sourceRequest; // [RULE10]
  // Anything that may legally raise the interrupt in the next cycle
  assign causeSeen = (setVec != 12'h000) || writeHit;

  a_serial3_blocked: assert property ( // [RULE1]
    @(posedge clock) disable iff (!arst_n)
    !enableOne_reg[3] |-> !sourceRequest[iebk_pkg::SRC_SERIAL3])
    else $error("Serial 3 request passed with enable low");

  a_serial3_passes: assert property ( // [RULE1]
    @(posedge clock) disable iff (!arst_n)
    serial3Event && !wdtStackReset && enableOne_next[3]
    |=> sourceRequest[iebk_pkg::SRC_SERIAL3] && irq)
    else $error("Enabled serial 3 event raised no request");

  a_serial2_gate: assert property ( // [RULE2]
    @(posedge clock) disable iff (!arst_n)
    serial2Event && !wdtStackReset
    |=> sourceRequest[iebk_pkg::SRC_SERIAL2] == enableOne_reg[2])
    else $error("Serial 2 request does not follow its enable");

  a_timer_gate: assert property ( // [RULE3]
    @(posedge clock) disable iff (!arst_n)
    timerEvent[0] && !wdtStackReset
    |=> sourceRequest[iebk_pkg::SRC_TIMER0] == enableTwo_reg[2])
    else $error("Timer 0 request does not follow its enable");

  a_timer_hold: assert property ( // [RULE3]
    @(posedge clock) disable iff (!arst_n)
    timerEvent[1] && !wdtStackReset && !enableTwo_next[3]
    |=> flagVec[iebk_pkg::SRC_TIMER1] && !sourceRequest[iebk_pkg::SRC_TIMER1])
    else $error("Disabled timer 1 flag wrong");

  a_pin_latch: assert property ( // [RULE4]
    @(posedge clock) disable iff (!arst_n)
    pinRise[iebk_pkg::SRC_PIN4] && !wdtStackReset
    |=> flagVec[iebk_pkg::SRC_PIN4]
        && sourceRequest[iebk_pkg::SRC_PIN4] == enableTwo_reg[1])
    else $error("Pin 4 edge not latched or gated");

  a_chip_enable_gate: assert property ( // [RULE5]
    @(posedge clock) disable iff (!arst_n)
    !enableThree_reg[0] |-> !sourceRequest[iebk_pkg::SRC_CHIP_ENABLE])
    else $error("Chip-enable request passed with enable low");

  a_serial3_read: assert property ( // [RULE6]
    @(posedge clock) disable iff (!arst_n)
    readHit && busReq.addr == iebk_pkg::SERIAL3_REQ_ADDR
    |=> readData == {3'h0, $past(flagVec[iebk_pkg::SRC_SERIAL3])})
    else $error("Serial 3 request read wrong");

  a_timer3_read: assert property ( // [RULE7]
    @(posedge clock) disable iff (!arst_n)
    readHit && busReq.addr == iebk_pkg::TIMER3_REQ_ADDR
    |=> readData[3:1] == 3'h0
        && readData[0] == $past(flagVec[iebk_pkg::SRC_TIMER3]))
    else $error("Timer 3 request read wrong");

  a_timer2_read: assert property ( // [RULE8]
    @(posedge clock) disable iff (!arst_n)
    readHit && busReq.addr == iebk_pkg::TIMER2_REQ_ADDR
    |=> readData == {3'h0, $past(flagVec[iebk_pkg::SRC_TIMER2])})
    else $error("Timer 2 request read wrong");

  a_wdt_clears: assert property ( // [RULE9]
    @(posedge clock) disable iff (!arst_n)
    wdtStackReset |=> enableVec == 12'h000 && flagVec == 12'h000 && !irq)
    else $error("Watchdog reset left state behind");

  a_enable_holds: assert property ( // [RULE9]
    @(posedge clock) disable iff (!arst_n)
    !wdtStackReset && !writeHit |=> $stable(enableVec))
    else $error("Enable bits changed without a write");

  a_irq_cause: assert property ( // [RULE10]
    @(posedge clock) disable iff (!arst_n)
    $rose(irq) |-> $past(causeSeen))
    else $error("Interrupt rose with no event or enable write");

  a_read_once: assert property ( // [RULE6]
    @(posedge clock) disable iff (!arst_n)
    !readHit |=> readData == 4'h0)
    else $error("Read data stood beyond one cycle");

  a_serial2_blocked: assert property ( // [RULE2]
    @(posedge clock) disable iff (!arst_n)
    !enableOne_reg[2] |-> !sourceRequest[iebk_pkg::SRC_SERIAL2])
    else $error("Serial 2 request passed with enable low");

  a_timer_blocked: assert property ( // [RULE3]
    @(posedge clock) disable iff (!arst_n)
    (sourceRequest[9:6] & ~{enableOne_reg[1:0], enableTwo_reg[3:2]}) == 4'h0)
    else $error("Timer request passed with enable low");

  a_pin_blocked: assert property ( // [RULE4]
    @(posedge clock) disable iff (!arst_n)
    (sourceRequest[5:1] & ~{enableTwo_reg[1:0], enableThree_reg[3:1]}) == 5'h00)
    else $error("Pin request passed with enable low");

  a_enable_one_write: assert property ( // [RULE1]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::ENABLE_ONE_ADDR && !wdtStackReset
    |=> enableOne_reg == $past(busReq.writeData))
    else $error("Enable one write did not land");

  a_enable_two_write: assert property ( // [RULE3]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::ENABLE_TWO_ADDR && !wdtStackReset
    |=> enableTwo_reg == $past(busReq.writeData))
    else $error("Enable two write did not land");

  a_enable_three_write: assert property ( // [RULE5]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::ENABLE_THREE_ADDR && !wdtStackReset
    |=> enableThree_reg == $past(busReq.writeData))
    else $error("Enable three write did not land");

  a_serial3_clear: assert property ( // [RULE6]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::SERIAL3_REQ_ADDR && busReq.writeData[0]
    && !serial3Event |=> !flagVec[iebk_pkg::SRC_SERIAL3])
    else $error("Serial 3 flag not cleared by a one");

  a_serial3_set_wins: assert property ( // [RULE6]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::SERIAL3_REQ_ADDR && serial3Event
    && !wdtStackReset |=> flagVec[iebk_pkg::SRC_SERIAL3])
    else $error("Serial 3 event lost to a clear");

  a_zero_write_keeps: assert property ( // [RULE6]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::SERIAL3_REQ_ADDR && !busReq.writeData[0]
    && !serial3Event && !wdtStackReset |=> $stable(flagVec[iebk_pkg::SRC_SERIAL3]))
    else $error("Writing zero changed the serial 3 flag");

  a_timer3_clear: assert property ( // [RULE7]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::TIMER3_REQ_ADDR && busReq.writeData[0]
    && !timerEvent[3] |=> !flagVec[iebk_pkg::SRC_TIMER3])
    else $error("Timer 3 flag not cleared by a one");

  a_timer2_clear: assert property ( // [RULE8]
    @(posedge clock) disable iff (!arst_n)
    writeHit && busReq.addr == iebk_pkg::TIMER2_REQ_ADDR && busReq.writeData[0]
    && !timerEvent[2] |=> !flagVec[iebk_pkg::SRC_TIMER2])
    else $error("Timer 2 flag not cleared by a one");

  a_chip_enable_latch: assert property ( // [RULE5]
    @(posedge clock) disable iff (!arst_n)
    pinRise[iebk_pkg::SRC_CHIP_ENABLE] && !wdtStackReset
    |=> flagVec[iebk_pkg::SRC_CHIP_ENABLE]
        && sourceRequest[iebk_pkg::SRC_CHIP_ENABLE] == enableThree_reg[0])
    else $error("Chip-enable edge not latched or gated");

  a_irq_follows: assert property ( // [RULE10]
    @(posedge clock) disable iff (!arst_n)
    flagVec[iebk_pkg::SRC_TIMER3] && enableOne_reg[1] |-> irq)
    else $error("Enabled timer 3 flag raised no interrupt");

  a_irq_idle: assert property ( // [RULE10]
    @(posedge clock) disable iff (!arst_n)
    enableVec == 12'h000 |-> !irq)
    else $error("Interrupt with every enable low");
endmodule : iebk_bank
`default_nettype wire

// [verif/iebk_src_model.sv]
// Purpose: Stand-in for internal peripheral sources and external pins
// Assumes: Events are one-cycle pulses; pins are slow levels
// Notes: Pins are held long enough to pass the two-stage synchroniser
`timescale 1ns/1ns
`default_nettype none
module iebk_src_model (
  // System
  input wire logic clock,
  // Internal sources
  output var logic serial3Event,
  output var logic serial2Event,
  output var logic [3:0] timerEvent,
  // External pins
  output var logic [4:0] extIrqPin,
  output var logic chipEnablePin
);
  initial begin
    serial3Event = 1'b0;
    serial2Event = 1'b0;
    timerEvent = 4'h0;
    extIrqPin = 5'h00;
    chipEnablePin = 1'b0;
  end

  // Source index 11..6 pulse for one cycle, 5..0 raise a pin level
  task automatic fire(input int idx);
    @(posedge clock);
    if (idx == 11) serial3Event <= 1'b1;
    else if (idx == 10) serial2Event <= 1'b1;
    else if (idx >= 6) timerEvent[idx-6] <= 1'b1;
    else if (idx >= 1) extIrqPin[idx-1] <= 1'b1;
    else chipEnablePin <= 1'b1;
    // Level must outlast sync and edge detect, or the edge is lost
    repeat ((idx >= 6) ? 1 : 4) @(posedge clock);
    serial3Event <= 1'b0;
    serial2Event <= 1'b0;
    timerEvent <= 4'h0;
    extIrqPin <= 5'h00;
    chipEnablePin <= 1'b0;
  endtask : fire

  // Slow level on the chip-enable pin, for reset-release checks
  task automatic hold_pin(input logic lvl);
    @(posedge clock);
    chipEnablePin <= lvl;
  endtask : hold_pin
endmodule : iebk_src_model
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the interrupt enable and request bank
// Assumes: Register port answers reads one cycle after the strobe
// Notes: Request register of source i sits at 3f minus i
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wdtStackReset = 1'b0;
  iebk_pkg::iebk_bus_req_type busReq = '0;
  logic [3:0] readData;
  logic serial3Event, serial2Event, chipEnablePin;
  logic [3:0] timerEvent;
  logic [4:0] extIrqPin;
  logic [11:0] sourceRequest;
  logic irq;
  int err_total = 0;
  int samples_checked = 0;

  iebk_bank iebk_bank_i (.clock(clock), .arst_n(arst_n), .wdtStackReset(wdtStackReset),
    .busReq(busReq), .readData(readData), .serial3Event(serial3Event),
    .serial2Event(serial2Event), .timerEvent(timerEvent), .extIrqPin(extIrqPin),
    .chipEnablePin(chipEnablePin), .sourceRequest(sourceRequest), .irq(irq));
  iebk_src_model iebk_src_model_i (.clock(clock), .serial3Event(serial3Event),
    .serial2Event(serial2Event), .timerEvent(timerEvent), .extIrqPin(extIrqPin),
    .chipEnablePin(chipEnablePin));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clock);
    busReq <= {a, d, 1'b1, 1'b0};
    @(posedge clock);
    busReq.writeStrobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [3:0] d);
    @(posedge clock);
    busReq <= {a, 4'h0, 1'b0, 1'b1};
    @(posedge clock);
    busReq.readStrobe <= 1'b0;
    #1;
    d = readData;
  endtask : rd

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Whole map after reset reads zero, unmapped holes included
  task automatic t_reset_values;
    logic [3:0] d;
    for (int a = 'h2d; a <= 'h3f; a++) begin
      rd(8'(a), d);
      chk("resetRead", {8'h00, d}, 12'h000);
    end
    chk("resetIrq", {11'h000, irq}, 12'h000);
  endtask : t_reset_values

  task automatic t_enable_rw;
    logic [3:0] d;
    wr(8'h2d, 4'ha);
    wr(8'h2e, 4'h5);
    wr(8'h2f, 4'hc);
    wr(8'h30, 4'hf);
    rd(8'h2d, d);
    chk("enableOne", {8'h00, d}, 12'h00a);
    rd(8'h2e, d);
    chk("enableTwo", {8'h00, d}, 12'h005);
    rd(8'h2f, d);
    chk("enableThree", {8'h00, d}, 12'h00c);
    rd(8'h30, d);
    chk("unmapped", {8'h00, d}, 12'h000);
    // Enables set but no flags pending
    chk("noFlagIrq", {11'h000, irq}, 12'h000);
    wr(8'h2d, 4'h0);
    wr(8'h2e, 4'h0);
    wr(8'h2f, 4'h0);
  endtask : t_enable_rw

  // Every source: masked flag, unmasked request, clear, enable alone
  task automatic t_sources;
    logic [3:0] d;
    logic [7:0] ea;
    for (int i = 0; i < 12; i++) begin
      ea = 8'h2f - 8'(i / 4);
      iebk_src_model_i.fire(i);
      repeat (6) @(posedge clock);
      #1;
      chk("maskedReq", sourceRequest, 12'h000);
      chk("maskedIrq", {11'h000, irq}, 12'h000);
      rd(8'h3f - 8'(i), d);
      chk("flagRead", {8'h00, d}, 12'h001);
      wr(ea, 4'h1 << (i % 4));
      chk("openReq", sourceRequest, 12'h001 << i);
      chk("openIrq", {11'h000, irq}, 12'h001);
      wr(8'h3f - 8'(i), 4'hf);
      chk("clearedReq", sourceRequest, 12'h000);
      rd(8'h3f - 8'(i), d);
      chk("clearedRead", {8'h00, d}, 12'h000);
      wr(ea, 4'h0);
    end
  endtask : t_sources

  task automatic t_wdt_clear;
    logic [3:0] d;
    wr(8'h2d, 4'hf);
    wr(8'h2f, 4'hf);
    iebk_src_model_i.fire(9);
    repeat (2) @(posedge clock);
    #1;
    chk("preWdtIrq", {11'h000, irq}, 12'h001);
    @(posedge clock);
    wdtStackReset <= 1'b1;
    @(posedge clock);
    wdtStackReset <= 1'b0;
    #1;
    chk("wdtReq", sourceRequest, 12'h000);
    rd(8'h2d, d);
    chk("wdtEnable", {8'h00, d}, 12'h000);
    rd(8'h36, d);
    chk("wdtFlag", {8'h00, d}, 12'h000);
    rd(8'h2f, d);
    chk("wdtEnable3", {8'h00, d}, 12'h000);
  endtask : t_wdt_clear

  // Power-on reset mid-run; a pin held high across release is no edge
  task automatic t_por_clear;
    logic [3:0] d;
    wr(8'h2d, 4'hf);
    iebk_src_model_i.fire(11);
    iebk_src_model_i.hold_pin(1'b1);
    repeat (6) @(posedge clock);
    #1;
    chk("prePorIrq", {11'h000, irq}, 12'h001);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("porIrq", {11'h000, irq}, 12'h000);
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk("porReq", sourceRequest, 12'h000);
    rd(8'h3f, d);
    chk("porPinFlag", {8'h00, d}, 12'h000);
    rd(8'h34, d);
    chk("porSerial3", {8'h00, d}, 12'h000);
    rd(8'h2d, d);
    chk("porEnable", {8'h00, d}, 12'h000);
    iebk_src_model_i.hold_pin(1'b0);
  endtask : t_por_clear

  // Run needs under a thousand cycles; limit leaves wide margin
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset_values();
    t_enable_rw();
    t_sources();
    t_wdt_clear();
    t_por_clear();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
